// ==== rtl/rsvrel_pkg.sv ====
// Package: constants, register map and types of the reservation release command block
//
// Behaviour
// [R1] The command either releases or clears the reservation held on the namespace.
// [R2] Parameters come from dword 10 and an in-memory structure; other fields are ignored.
// [R3] Page-list transfers use entries one and two; scatter-gather uses entry one only.
// [R4] The 128-bit buffer pointer locates the structure; data flows host to controller.
// [R5] For a release action, dword 10 bits 15:08 give the reservation kind to release.
// [R6] A release whose kind differs from the held kind fails with invalid field.
// [R7] With dword 10 bit 03 set, the current key check always passes.
// [R8] Dword 10 bits 02:00: 000b release, 001b clear, others reserved.
// [R9] Bytes 7:0 of the structure hold the host key, compared to the registered key.
// [R10] On finishing, a completion with the status goes to the associated completion queue.
// [R11] A successful clear increments the 32-bit wrapping generation counter.
// [R12] Held kind zero means no reservation; any non-zero value names the held kind.
// [R13] A reserved action fails with invalid field and leaves reservation state unchanged.
package rsvrel_pkg;
   // ==========================================================
   // Command dword 10 fields
   localparam int ACT_LSB = 0;
   localparam int ACT_W = 3;
   localparam int SKIP_BIT = 3;
   localparam int KIND_LSB = 8;
   localparam int KIND_W = 8;
   localparam logic [2:0] ACT_RELEASE = 3'h0;
   localparam logic [2:0] ACT_CLEAR = 3'h1;
   localparam logic [7:0] KIND_NONE = 8'h00;

   // ==========================================================
   // Completion status codes
   localparam logic [7:0] ST_SUCCESS = 8'h00;
   localparam logic [7:0] ST_INVALID_FIELD = 8'h02;
   localparam logic [7:0] ST_KEY_CONFLICT = 8'h83;

   // ==========================================================
   // Register byte offsets on the APB
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_KEY_LO = 8'h04;
   localparam logic [7:0] OFF_KEY_HI = 8'h08;
   localparam logic [7:0] OFF_HELD = 8'h0c;
   localparam logic [7:0] OFF_GEN = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFF_LAST = 8'h1c;

   // Field positions and reset values
   localparam int CTRL_EN_BIT = 0;
   localparam int LAST_BUSY_BIT = 8;
   localparam int IRQ_W = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;
   localparam logic [31:0] GEN_RESET = 32'h0000_0000;
   localparam logic [63:0] KEY_RESET = 64'h0000_0000_0000_0000;

   // ==========================================================
   // Command engine states, Gray coded along idle-fetch-wait-exec-post
   typedef enum logic [2:0] {
      RSV_IDLE  = 3'h0,
      RSV_FETCH = 3'h1,
      RSV_WAIT  = 3'h3,
      RSV_EXEC  = 3'h2,
      RSV_POST  = 3'h6
   } rsvrel_state_type;
endpackage : rsvrel_pkg

// ==== rtl/rsvrel_decode.sv ====
// Module: field decode of command dword 10
`timescale 1ns/1ps
`default_nettype none
module rsvrel_decode (
   input wire logic [31:0] dw10,
   output logic is_release,
   output logic is_clear,
   output logic is_reserved,
   output logic skip_key_check,
   output logic [7:0] reservation_kind
);
   // ==========================================================
   // Action and field extraction; bits 31:16 and 07:04 are never looked at
   wire logic [2:0] release_action = dw10[rsvrel_pkg::ACT_LSB +: rsvrel_pkg::ACT_W]; // R2
   assign is_release = (release_action == rsvrel_pkg::ACT_RELEASE); // R8
   assign is_clear = (release_action == rsvrel_pkg::ACT_CLEAR); // R8
   assign is_reserved = !is_release && !is_clear; // R8
   assign skip_key_check = dw10[rsvrel_pkg::SKIP_BIT];
   assign reservation_kind = dw10[rsvrel_pkg::KIND_LSB +: rsvrel_pkg::KIND_W]; // R5
endmodule : rsvrel_decode
`default_nettype wire

// ==== rtl/rsvrel_irq.sv ====
// Module: sticky event flags, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module rsvrel_irq #(
   parameter int W = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [W-1:0] event_set,
   input wire logic [W-1:0] clear_ones,
   input wire logic [W-1:0] mask_in,
   input wire logic mask_we,
   output logic [W-1:0] stat,
   output logic [W-1:0] mask,
   output logic irq
);
   logic [W-1:0] stat_r;
   logic [W-1:0] mask_r;

   // ==========================================================
   // Set beats clear, so an event in the clearing cycle survives
   wire logic [W-1:0] stat_nxt = event_set | (stat_r & ~clear_ones);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= '0;
         mask_r <= '0;
      end else if (ce) begin
         stat_r <= stat_nxt;
         if (mask_we) begin
            mask_r <= mask_in;
         end
      end
   end

   assign stat = stat_r;
   assign mask = mask_r;
   assign irq = |(stat_r & mask_r);
endmodule : rsvrel_irq
`default_nettype wire

// ==== rtl/rsvrel_top.sv ====
// Module: reservation release command engine with APB register file
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rsvrel_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Command from the submission queue front end
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [31:0] cmd_dw10,
   input wire logic [127:0] buffer_pointer,
   input wire logic cmd_use_sgl,
   input wire logic [15:0] cmd_id,
   input wire logic [15:0] cmd_cqid,
   // Host memory read of the key structure
   output logic rd_req_valid,
   input wire logic rd_req_ready,
   output logic [63:0] rd_req_addr,
   output logic [63:0] rd_req_addr2,
   output logic rd_req_sgl,
   input wire logic rd_rsp_valid,
   input wire logic [63:0] rd_rsp_data,
   // Completion entry toward the completion queue
   output logic cpl_valid,
   input wire logic cpl_ready,
   output logic [15:0] cpl_cqid,
   output logic [15:0] cpl_cid,
   output logic [7:0] cpl_status,
   // Interrupt
   output logic irq
);
   // ==========================================================
   // State and registers
   rsvrel_pkg::rsvrel_state_type state_r, state_nxt;
   logic enable_r;
   logic [63:0] reg_key_r;
   logic [7:0] held_kind_r;
   logic [31:0] gen_r;
   logic [31:0] dw10_r;
   logic [127:0] ptr_r;
   logic use_sgl_r;
   logic [15:0] cid_r;
   logic [15:0] cqid_r;
   logic [63:0] host_key_r;
   logic [7:0] status_r;
   logic [7:0] last_status_r;
   logic [7:0] status_nxt;

   // ==========================================================
   // APB decode; the slave never waits, unmapped addresses error
   wire logic apb_acc = psel && penable;
   wire logic apb_wr = apb_acc && pwrite && ce;
   wire logic hit_ctrl = (paddr == rsvrel_pkg::OFF_CTRL);
   wire logic hit_klo = (paddr == rsvrel_pkg::OFF_KEY_LO);
   wire logic hit_khi = (paddr == rsvrel_pkg::OFF_KEY_HI);
   wire logic hit_held = (paddr == rsvrel_pkg::OFF_HELD);
   wire logic hit_gen = (paddr == rsvrel_pkg::OFF_GEN);
   wire logic hit_istat = (paddr == rsvrel_pkg::OFF_IRQ_STAT);
   wire logic hit_imask = (paddr == rsvrel_pkg::OFF_IRQ_MASK);
   wire logic hit_last = (paddr == rsvrel_pkg::OFF_LAST);
   wire logic hit_any = hit_ctrl | hit_klo | hit_khi | hit_held | hit_gen | hit_istat
                        | hit_imask | hit_last;
   assign pready = 1'b1;
   assign pslverr = apb_acc && !hit_any;

   // ==========================================================
   // Field decode of the latched dword 10
   logic act_release, act_clear, skip_key_check;
   logic [7:0] reservation_kind;
   logic in_reserved;

   rsvrel_decode u_dec_cur (.dw10(dw10_r), .is_release(act_release), .is_clear(act_clear),
      .is_reserved(), .skip_key_check(skip_key_check), .reservation_kind(reservation_kind));
   // Only the reserved-action flag of the incoming word matters before capture
   rsvrel_decode u_dec_in (.dw10(cmd_dw10), .is_release(), .is_clear(), .is_reserved(in_reserved),
      .skip_key_check(), .reservation_kind());

   // ==========================================================
   // Outcome of the command once the key is in hand
   wire logic cmd_take = cmd_valid && cmd_ready && ce;
   wire logic current_host_key_ok = skip_key_check || (host_key_r == reg_key_r); // R7 R9
   wire logic held_none = (held_kind_r == rsvrel_pkg::KIND_NONE); // R12
   wire logic kind_mismatch = act_release && !held_none
                              && (reservation_kind != held_kind_r); // R6
   wire logic exec_ok = (state_r == rsvrel_pkg::RSV_EXEC) && current_host_key_ok
                        && !kind_mismatch;
   wire logic drop_hold = exec_ok; // R1
   wire logic bump_gen = exec_ok && act_clear; // R11
   wire logic cpl_take = cpl_valid && cpl_ready && ce;

   // Status chosen in the execute step; a key failure outranks the kind check
   always_comb begin
      status_nxt = rsvrel_pkg::ST_SUCCESS;
      if (!current_host_key_ok) begin
         status_nxt = rsvrel_pkg::ST_KEY_CONFLICT; // R9
      end else if (kind_mismatch) begin
         status_nxt = rsvrel_pkg::ST_INVALID_FIELD; // R6
      end
   end

   // ==========================================================
   // Command sequence
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         rsvrel_pkg::RSV_IDLE: begin
            if (cmd_take) begin
               // Reserved action skips the fetch and touches nothing
               state_nxt = in_reserved ? rsvrel_pkg::RSV_POST : rsvrel_pkg::RSV_FETCH; // R13
            end
         end
         rsvrel_pkg::RSV_FETCH: begin
            if (rd_req_ready) begin
               state_nxt = rsvrel_pkg::RSV_WAIT;
            end
         end
         rsvrel_pkg::RSV_WAIT: begin
            if (rd_rsp_valid) begin
               state_nxt = rsvrel_pkg::RSV_EXEC;
            end
         end
         rsvrel_pkg::RSV_EXEC: begin
            state_nxt = rsvrel_pkg::RSV_POST;
         end
         rsvrel_pkg::RSV_POST: begin
            if (cpl_ready) begin
               state_nxt = rsvrel_pkg::RSV_IDLE; // R10
            end
         end
         default: begin
            state_nxt = rsvrel_pkg::RSV_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= rsvrel_pkg::RSV_IDLE;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // Command capture, key capture and completion status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dw10_r <= '0;
         ptr_r <= '0;
         use_sgl_r <= 1'b0;
         cid_r <= '0;
         cqid_r <= '0;
         host_key_r <= rsvrel_pkg::KEY_RESET;
         status_r <= rsvrel_pkg::ST_SUCCESS;
      end else if (ce) begin
         if (cmd_take) begin
            dw10_r <= cmd_dw10; // R2
            ptr_r <= buffer_pointer; // R4
            use_sgl_r <= cmd_use_sgl;
            cid_r <= cmd_id;
            cqid_r <= cmd_cqid; // R10
            status_r <= in_reserved ? rsvrel_pkg::ST_INVALID_FIELD
                                    : rsvrel_pkg::ST_SUCCESS; // R13
         end
         if ((state_r == rsvrel_pkg::RSV_WAIT) && rd_rsp_valid) begin
            host_key_r <= rd_rsp_data; // R9
         end
         if (state_r == rsvrel_pkg::RSV_EXEC) begin
            status_r <= status_nxt;
         end
      end
   end

   // ==========================================================
   // Reservation state; the engine's update wins over a software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_kind_r <= rsvrel_pkg::KIND_NONE;
         gen_r <= rsvrel_pkg::GEN_RESET;
         enable_r <= 1'b0;
         reg_key_r <= rsvrel_pkg::KEY_RESET;
         last_status_r <= rsvrel_pkg::ST_SUCCESS;
      end else if (ce) begin
         if (drop_hold) begin
            held_kind_r <= rsvrel_pkg::KIND_NONE; // R1 R12
         end else if (apb_wr && hit_held) begin
            held_kind_r <= pwdata[7:0];
         end
         if (bump_gen) begin
            gen_r <= gen_r + 32'h0000_0001; // R11
         end
         if (apb_wr && hit_ctrl) begin
            enable_r <= pwdata[rsvrel_pkg::CTRL_EN_BIT];
         end
         if (apb_wr && hit_klo) begin
            reg_key_r[31:0] <= pwdata;
         end
         if (apb_wr && hit_khi) begin
            reg_key_r[63:32] <= pwdata;
         end
         if (cpl_take) begin
            last_status_r <= status_r;
         end
      end
   end

   // ==========================================================
   // Interrupt flags: done on every completion, error on a failing one
   wire logic [1:0] irq_events = {cpl_take && (status_r != rsvrel_pkg::ST_SUCCESS), cpl_take};
   logic [1:0] irq_stat, irq_mask;
   rsvrel_irq #(.W(rsvrel_pkg::IRQ_W)) u_irq (.pclk(pclk), .presetn(presetn), .ce(ce),
      .event_set(irq_events), .clear_ones((apb_wr && hit_istat) ? pwdata[1:0] : 2'h0),
      .mask_in(pwdata[1:0]), .mask_we(apb_wr && hit_imask), .stat(irq_stat), .mask(irq_mask),
      .irq(irq));

   // ==========================================================
   // Read mux; reserved bits read as zero
   wire logic busy = (state_r != rsvrel_pkg::RSV_IDLE);
   always_comb begin
      prdata = 32'h0000_0000;
      if (hit_ctrl) begin
         prdata[rsvrel_pkg::CTRL_EN_BIT] = enable_r;
      end else if (hit_klo) begin
         prdata = reg_key_r[31:0];
      end else if (hit_khi) begin
         prdata = reg_key_r[63:32];
      end else if (hit_held) begin
         prdata[7:0] = held_kind_r;
      end else if (hit_gen) begin
         prdata = gen_r;
      end else if (hit_istat) begin
         prdata[1:0] = irq_stat;
      end else if (hit_imask) begin
         prdata[1:0] = irq_mask;
      end else if (hit_last) begin
         prdata[7:0] = last_status_r;
         prdata[rsvrel_pkg::LAST_BUSY_BIT] = busy;
      end
   end

   // ==========================================================
   // Outward handshakes; the key is 8 bytes so one read covers it
   assign cmd_ready = enable_r && (state_r == rsvrel_pkg::RSV_IDLE);
   assign rd_req_valid = (state_r == rsvrel_pkg::RSV_FETCH);
   assign rd_req_addr = ptr_r[63:0]; // R3 R4
   // Second page entry only matters for page lists; zero for scatter-gather
   assign rd_req_addr2 = use_sgl_r ? 64'h0000_0000_0000_0000 : ptr_r[127:64]; // R3
   assign rd_req_sgl = use_sgl_r;
   assign cpl_valid = (state_r == rsvrel_pkg::RSV_POST); // R10
   assign cpl_cqid = cqid_r;
   assign cpl_cid = cid_r;
   assign cpl_status = status_r;

   // ==========================================================
   // Checks
   sequence s_exec_release_match;
      (state_r == rsvrel_pkg::RSV_EXEC) && act_release && current_host_key_ok
      && !held_none && (reservation_kind == held_kind_r);
   endsequence
   sequence s_post_wait;
      cpl_valid && !cpl_ready && ce;
   endsequence
   property p_reserved_action;
      @(posedge pclk) disable iff (!presetn)
      (cmd_take && in_reserved) |=> cpl_valid && (cpl_status == rsvrel_pkg::ST_INVALID_FIELD)
                                    && (held_kind_r == $past(held_kind_r))
                                    && (gen_r == $past(gen_r));
   endproperty
   a_reserved_action: assert property (p_reserved_action) // R13
      else $error("reserved action not rejected cleanly");
   property p_fetch_after_take;
      @(posedge pclk) disable iff (!presetn)
      (cmd_take && !in_reserved) |=> rd_req_valid && (rd_req_addr == $past(buffer_pointer[63:0]));
   endproperty
   a_fetch_after_take: assert property (p_fetch_after_take) // R4
      else $error("key fetch not issued from the buffer pointer");
   property p_sgl_second_entry;
      @(posedge pclk) disable iff (!presetn)
      (rd_req_valid && rd_req_sgl) |-> (rd_req_addr2 == 64'h0000_0000_0000_0000);
   endproperty
   a_sgl_second_entry: assert property (p_sgl_second_entry) // R3
      else $error("second entry used in scatter-gather mode");
   property p_clear_bumps_gen;
      @(posedge pclk) disable iff (!presetn)
      ((state_r == rsvrel_pkg::RSV_EXEC) && act_clear && current_host_key_ok && ce)
      |=> (gen_r == $past(gen_r) + 32'h0000_0001) && held_none
          && (cpl_status == rsvrel_pkg::ST_SUCCESS);
   endproperty
   a_clear_bumps_gen: assert property (p_clear_bumps_gen) // R11
      else $error("successful clear did not bump generation");
   property p_kind_mismatch;
      @(posedge pclk) disable iff (!presetn)
      ((state_r == rsvrel_pkg::RSV_EXEC) && current_host_key_ok && kind_mismatch && ce)
      |=> (cpl_status == rsvrel_pkg::ST_INVALID_FIELD) && $stable(held_kind_r);
   endproperty
   a_kind_mismatch: assert property (p_kind_mismatch) // R6
      else $error("mismatching release kind not rejected");
   property p_release_drops;
      @(posedge pclk) disable iff (!presetn)
      (s_exec_release_match and (ce && 1'b1)) |=> held_none && !$stable(held_kind_r)
                                                  && $stable(gen_r);
   endproperty
   a_release_drops: assert property (p_release_drops) // R1
      else $error("matching release did not drop the reservation");
   property p_skip_key;
      @(posedge pclk) disable iff (!presetn)
      ((state_r == rsvrel_pkg::RSV_EXEC) && skip_key_check && ce)
      |=> (cpl_status != rsvrel_pkg::ST_KEY_CONFLICT);
   endproperty
   a_skip_key: assert property (p_skip_key) // R7
      else $error("key check not bypassed");
   property p_key_conflict;
      @(posedge pclk) disable iff (!presetn)
      ((state_r == rsvrel_pkg::RSV_EXEC) && !skip_key_check && (host_key_r != reg_key_r) && ce)
      |=> (cpl_status == rsvrel_pkg::ST_KEY_CONFLICT) && $stable(held_kind_r);
   endproperty
   a_key_conflict: assert property (p_key_conflict) // R9
      else $error("wrong key not refused");
   property p_cpl_holds;
      @(posedge pclk) disable iff (!presetn)
      s_post_wait |=> cpl_valid && $stable(cpl_status) && $stable(cpl_cqid);
   endproperty
   a_cpl_holds: assert property (p_cpl_holds) // R10
      else $error("completion dropped before acceptance");
endmodule : rsvrel_top
`default_nettype wire

// ==== verif/rsvrel_host_model.sv ====
// Host model: answers key structure reads and accepts completion entries
`timescale 1ns/1ps
`default_nettype none
module rsvrel_host_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [63:0] host_key,
   input wire logic [1:0] lag,
   input wire logic rd_req_valid,
   output logic rd_req_ready,
   output logic rd_rsp_valid,
   output logic [63:0] rd_rsp_data,
   input wire logic cpl_valid,
   output logic cpl_ready
);
   logic pend;
   logic [1:0] req_cnt;
   logic [1:0] rsp_cnt;
   logic [1:0] cpl_cnt;
   // ==========================================================
   // Memory side; lag stretches every answer to exercise slow hosts
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {rd_req_ready, rd_rsp_valid, cpl_ready, pend} <= 4'h0;
         {req_cnt, rsp_cnt, cpl_cnt} <= 6'h00;
         rd_rsp_data <= 64'h0;
      end else begin
         rd_rsp_valid <= 1'b0;
         // Idle data toggles so a stale read never looks valid
         rd_rsp_data <= ~rd_rsp_data;
         if (rd_req_valid && !rd_req_ready) begin
            rd_req_ready <= (req_cnt >= lag);
            req_cnt <= (req_cnt >= lag) ? 2'h0 : req_cnt + 2'h1;
         end else begin
            rd_req_ready <= 1'b0;
         end
         if (rd_req_valid && rd_req_ready) begin
            pend <= 1'b1;
         end else if (pend) begin
            rsp_cnt <= (rsp_cnt >= lag) ? 2'h0 : rsp_cnt + 2'h1;
            if (rsp_cnt >= lag) begin
               pend <= 1'b0;
               rd_rsp_valid <= 1'b1;
               rd_rsp_data <= host_key;
            end
         end
         if (cpl_valid && !cpl_ready) begin
            cpl_ready <= (cpl_cnt >= lag);
            cpl_cnt <= (cpl_cnt >= lag) ? 2'h0 : cpl_cnt + 2'h1;
         end else begin
            cpl_ready <= 1'b0;
         end
      end
   end
endmodule : rsvrel_host_model
`default_nettype wire

// ==== verif/test_reservation_release_cmd.sv ====
// Testbench: APB setup and release or clear commands against a host model
`timescale 1ns/1ps
`default_nettype none
module test_reservation_release_cmd;
   localparam logic [127:0] BP = 128'h1111_2222_3333_4444_5555_6666_7777_8000;
   localparam logic [63:0] KEY = 64'h0123_4567_89ab_cdef;
   logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
   logic [7:0] paddr = 8'h00, cpl_status;
   logic [31:0] pwdata = 32'h0, prdata, cmd_dw10 = 32'h0, q;
   logic cmd_valid = 1'b0, cmd_ready, cmd_use_sgl = 1'b0, err, req_sgl;
   logic [15:0] cmd_id = 16'h0, cmd_cqid = 16'h0005, cpl_cqid, cpl_cid;
   logic rd_req_valid, rd_req_ready, rd_req_sgl, rd_rsp_valid, cpl_valid, cpl_ready;
   logic [63:0] rd_req_addr, rd_req_addr2, rd_rsp_data, req_addr, req_addr2;
   logic [63:0] host_key = 64'h0;
   logic [1:0] lag = 2'h0;
   logic [7:0] st;
   int error_cnt = 0, n_checks = 0;
   rsvrel_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_dw10(cmd_dw10), .buffer_pointer(BP), .cmd_use_sgl(cmd_use_sgl), .cmd_id(cmd_id),
      .cmd_cqid(cmd_cqid), .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready),
      .rd_req_addr(rd_req_addr), .rd_req_addr2(rd_req_addr2), .rd_req_sgl(rd_req_sgl),
      .rd_rsp_valid(rd_rsp_valid), .rd_rsp_data(rd_rsp_data), .cpl_valid(cpl_valid),
      .cpl_ready(cpl_ready), .cpl_cqid(cpl_cqid), .cpl_cid(cpl_cid),
      .cpl_status(cpl_status), .irq(irq));
   rsvrel_host_model u_host (.pclk(pclk), .presetn(presetn), .host_key(host_key),
      .lag(lag), .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready),
      .rd_rsp_valid(rd_rsp_valid), .rd_rsp_data(rd_rsp_data), .cpl_valid(cpl_valid),
      .cpl_ready(cpl_ready));
   // ==========================================================
   // Clock and capture of the memory read request at its handshake
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (rd_req_valid === 1'b1 && rd_req_ready === 1'b1) begin
         req_addr <= rd_req_addr;
         req_addr2 <= rd_req_addr2;
         req_sgl <= rd_req_sgl;
      end
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      // No wait-state count is assumed; only the watchdog ends a stall
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask : apb
   task automatic run(input logic [31:0] dw, input logic sgl);
      @(posedge pclk);
      {cmd_valid, cmd_dw10, cmd_use_sgl} <= {1'b1, dw, sgl};
      cmd_id <= cmd_id + 16'h0101;
      do begin
         @(posedge pclk);
      end while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      do begin
         @(posedge pclk);
      end while (cpl_valid !== 1'b1 || cpl_ready !== 1'b1);
      st = cpl_status;
      chk({cpl_cqid, cpl_cid}, {cmd_cqid, cmd_id});
   endtask : run
   task automatic stop_test;
      if (error_cnt == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   // ==========================================================
   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      stop_test;
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, rsvrel_pkg::OFF_HELD, 32'h0);
      chk(q, rsvrel_pkg::KIND_NONE);
      apb(1'b0, rsvrel_pkg::OFF_GEN, 32'h0);
      chk(q, rsvrel_pkg::GEN_RESET);
      apb(1'b0, 8'h40, 32'h0);
      chk({err, q}, {1'b1, 32'h0});
      apb(1'b1, rsvrel_pkg::OFF_CTRL, 32'h1);
      apb(1'b1, rsvrel_pkg::OFF_KEY_LO, KEY[31:0]);
      apb(1'b1, rsvrel_pkg::OFF_KEY_HI, KEY[63:32]);
      apb(1'b1, rsvrel_pkg::OFF_IRQ_MASK, 32'h3);
      apb(1'b1, rsvrel_pkg::OFF_HELD, 32'h5);
      // Wrong key from a slow host, reserved upper bits set
      {host_key, lag} <= {~KEY, 2'h2};
      run(32'hffff_0500, 1'b0);
      chk(st, rsvrel_pkg::ST_KEY_CONFLICT);
      apb(1'b0, rsvrel_pkg::OFF_HELD, 32'h0);
      chk(q, 32'h5);
      {host_key, lag} <= {KEY, 2'h0};
      run(32'h0000_0600, 1'b0);
      chk(st, rsvrel_pkg::ST_INVALID_FIELD);
      // Wrong key again, but the check is skipped
      host_key <= ~KEY;
      run(32'h0000_0508, 1'b0);
      chk(st, rsvrel_pkg::ST_SUCCESS);
      apb(1'b0, rsvrel_pkg::OFF_HELD, 32'h0);
      chk(q, 32'h0);
      chk(req_addr, BP[63:0]);
      chk({req_sgl, req_addr2}, {1'b0, BP[127:64]});
      apb(1'b1, rsvrel_pkg::OFF_HELD, 32'h3);
      host_key <= KEY;
      run(32'h0000_7701, 1'b1);
      chk(st, rsvrel_pkg::ST_SUCCESS);
      chk({req_sgl, req_addr2}, {1'b1, 64'h0});
      apb(1'b0, rsvrel_pkg::OFF_GEN, 32'h0);
      chk(q, 32'h1);
      apb(1'b1, rsvrel_pkg::OFF_HELD, 32'h3);
      for (int a = 2; a < 8; a++) begin
         run({24'h000003, 5'h0, 3'(a)}, 1'b0);
         chk(st, rsvrel_pkg::ST_INVALID_FIELD);
      end
      apb(1'b0, rsvrel_pkg::OFF_HELD, 32'h0);
      chk(q, 32'h3);
      apb(1'b0, rsvrel_pkg::OFF_GEN, 32'h0);
      chk(q, 32'h1);
      apb(1'b0, rsvrel_pkg::OFF_LAST, 32'h0);
      chk(q[8:0], {1'b0, rsvrel_pkg::ST_INVALID_FIELD});
      // Interrupt: both events seen, then masked, then cleared
      @(negedge pclk);
      chk(irq, 1'b1);
      apb(1'b0, rsvrel_pkg::OFF_IRQ_STAT, 32'h0);
      chk(q, 32'h3);
      apb(1'b1, rsvrel_pkg::OFF_IRQ_MASK, 32'h0);
      @(negedge pclk);
      chk(irq, 1'b0);
      apb(1'b1, rsvrel_pkg::OFF_IRQ_STAT, 32'h3);
      apb(1'b1, rsvrel_pkg::OFF_IRQ_MASK, 32'h3);
      @(negedge pclk);
      chk(irq, 1'b0);
      apb(1'b0, rsvrel_pkg::OFF_IRQ_STAT, 32'h0);
      chk(q, 32'h0);
      // Writes are lost while the clock enable is low
      ce <= 1'b0;
      apb(1'b1, rsvrel_pkg::OFF_HELD, 32'h9);
      ce <= 1'b1;
      apb(1'b0, rsvrel_pkg::OFF_HELD, 32'h0);
      chk(q, 32'h3);
      stop_test;
   end
endmodule : test_reservation_release_cmd
`default_nettype wire
